//--- rsfg_pkg.sv
/*
  Package for the reset-source recorder and flash write guard: register
  offsets, field positions, reset values, timing constants, carriers and
  state encodings. Assumes a single 125 MHz system clock.
*/
// Operation
// - Watchdog enabled after reset, clock divided by twelve
// - Watchdog expiry resets and sets bit 3
// - Flash write above lock address causes error reset
// - Code read above lock address causes error reset
// - Branch above lock address causes error reset
// - Access forbidden by security causes error reset
// - Write or erase without high supply monitor errors
// - Flash error reset sets bit 6
// - Writing 1 to bit 4 forces reset
// - Bit 5 enables comparator reset, shows cause
// - Bit 2 enables clock detector, shows cause
// - Bit 1 set by power-on, selects monitor
// - Bit 0 set only by pin reset
// - Write only clears bits; erase fills page
// - Operations self-timed, code stalled until done
// - Keys 0xA5 then 0xF1 unlock one operation
// - Bad key or early operation locks until reset
// - Relock after every completed write or erase
// - Write enable steers data writes, held until cleared
// - One data write with both enables erases page
// - Short-address writes never reach flash above 0x00FF
package rsfg_pkg;
  localparam logic [7:0] RST_CAUSE_ADDR = 8'hEF;
  localparam logic [7:0] PS_CTRL_ADDR = 8'hB6;
  localparam logic [7:0] FL_KEY_ADDR = 8'hB5;
  localparam int BIT_CMP = 5;
  localparam int BIT_SW = 4;
  localparam int BIT_MCD = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_WR_EN = 0;
  localparam int BIT_ERASE_EN = 1;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] SHORT_HIGH = 8'h00;
  localparam int PAGE_BITS = 9;
  localparam int WD_DIV = 12;
  localparam int WD_LIMIT = 256;
  localparam logic [4:0] RST_HOLD = 5'h10;
  localparam logic [3:0] SYNC_RESET = 4'h1;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 40000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  typedef struct packed {
    logic ferr;
    logic cmp;
    logic sw;
    logic wdog;
    logic mcd;
    logic por;
    logic pin;
  } rsfg_cause_s;
  localparam rsfg_cause_s CAUSE_POR = 7'h02;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsfg_sfr_s;
  typedef struct packed {
    logic write;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
  } rsfg_fl_cmd_s;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ONE = 2'b01,
    KEY_OPEN = 2'b10,
    KEY_DEAD = 2'b11
  } rsfg_key_e;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_FETCH = 2'b01,
    OP_PROG = 2'b10,
    OP_ERASE = 2'b11
  } rsfg_op_e;
endpackage : rsfg_pkg

//--- rsfg_watchdog.sv
/*
  Counter-array watchdog in its default mode: system clock divided by
  twelve, expires after LIMIT ticks without a kick. Assumes clear comes
  from the system reset logic on the same clock.
*/
`timescale 1ns/1ps
module rsfg_watchdog import rsfg_pkg::*; #(
  parameter int LIMIT = WD_LIMIT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic kick,
  input wire logic disable_wd,
  output logic expire
);
  logic [3:0] pre;
  logic [$clog2(LIMIT)-1:0] cnt;
  logic tick;

  // Divide by twelve from any reset onward
  assign tick = (pre == 4'(WD_DIV - 1));

  // Prescaler
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre <= '0;
    end else if (clear || tick) begin
      pre <= '0;
    end else begin
      pre <= pre + 4'h1;
    end
  end

  // Tick counter and one-cycle expiry pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (clear || kick || disable_wd) begin
        cnt <= '0;
      end else if (tick) begin
        if (cnt == ($clog2(LIMIT))'(LIMIT - 1)) begin
          cnt <= '0;
          expire <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : rsfg_watchdog

//--- rsfg_op_timer.sv
/*
  Down counter that times one flash write or erase. Assumes start is a
  single-cycle pulse and load is at least one.
*/
`timescale 1ns/1ps
module rsfg_op_timer #(
  parameter int W = 22
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);
  logic [W-1:0] cnt;
  logic run;

  // Count load cycles after start, then pulse done
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= load - 1'b1;
        run <= 1'b1;
      end else if (run) begin
        if (cnt == '0) begin
          run <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule : rsfg_op_timer

//--- rsfg_guard.sv
/*
  Reset-source register and flash write/erase guard. Records the cause
  of each system reset, drives the system reset, decodes the reset
  source, flash key and program store control registers, and sequences
  self-timed flash byte writes and page erases. Assumes reset_n is the
  power-on reset, the flash array answers a read one cycle after its
  address, and the reset pin is only ever an input here.
*/
`timescale 1ns/1ps
module rsfg_guard import rsfg_pkg::*; #(
  parameter int WRITE_CNT = WRITE_CYCLES,
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int WD_TICKS = WD_LIMIT,
  parameter int TMR_W = 22
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire rsfg_sfr_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic xwr_valid,
  input wire logic [15:0] xwr_addr,
  input wire logic [7:0] xwr_data,
  input wire logic xwr_short,
  input wire logic code_rd_valid,
  input wire logic [15:0] code_rd_addr,
  input wire logic branch_valid,
  input wire logic [15:0] branch_addr,
  input wire logic [15:0] exec_addr,
  input wire logic [15:0] lock_byte_addr,
  input wire logic [7:0] lock_byte,
  input wire logic wd_kick,
  input wire logic wd_disable,
  input wire logic supply_monitor_enable,
  input wire logic supply_monitor_level,
  input wire logic supply_trip,
  input wire logic rst_pin_n,
  input wire logic mcd_timeout,
  input wire logic comparator_low,
  input wire logic [7:0] fl_rdata,
  output rsfg_fl_cmd_s fl_cmd,
  output logic cpu_stall,
  output logic sys_reset
);
  logic [3:0] sync1, sync2;
  rsfg_cause_s reset_flags, src, next_flags;
  logic event_any, cmp_en, mcd_en, vdd_src_en, ps_wr_en, ps_erase_en;
  logic [4:0] hold_cnt;
  rsfg_key_e key_state;
  rsfg_op_e op_state;
  logic [7:0] wdata_hold;
  logic live, rst_wr, ps_wr, key_wr, short_block, fl_attempt, ferr_src;
  logic op_go, wd_expire, tmr_start, tmr_done;
  logic [TMR_W-1:0] tmr_load;

  // Page lies in the secured region set by the lock byte
  function automatic logic is_locked(input logic [15:0] a,
                                     input logic [15:0] lb_addr,
                                     input logic [7:0] lb);
    logic [7:0] n;
    logic [7:0] page;
    n = ~lb;
    page = {1'b0, a[15:PAGE_BITS]};
    return (page < n) ||
           ((n != 8'h00) && (a[15:PAGE_BITS] == lb_addr[15:PAGE_BITS]));
  endfunction : is_locked
  // Two-flop synchronisers for pin and analog reset sources
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else begin
      sync1 <= {supply_trip, comparator_low, mcd_timeout, rst_pin_n};
      sync2 <= sync1;
    end
  end

  // Writes, code reads and branches are accepted only outside reset and flash operations; register reads always
  assign live = !sys_reset && (op_state == OP_IDLE);
  assign rst_wr = live && sfr_req.wr && (sfr_req.addr == RST_CAUSE_ADDR);
  assign ps_wr = live && sfr_req.wr && (sfr_req.addr == PS_CTRL_ADDR);
  assign key_wr = live && sfr_req.wr && (sfr_req.addr == FL_KEY_ADDR);
  // Short-address writes above the first 256 bytes never reach flash
  assign short_block = xwr_short && (xwr_addr[15:8] != SHORT_HIGH);
  // Data write steered to flash while write enable is set
  assign fl_attempt = live && xwr_valid && ps_wr_en && !short_block;
  // Flash error sources
  always_comb begin
    ferr_src = 1'b0;
    if (fl_attempt && (xwr_addr > lock_byte_addr)) begin
      ferr_src = 1'b1;
    end
    if (live && code_rd_valid && (code_rd_addr > lock_byte_addr)) begin
      ferr_src = 1'b1;
    end
    if (live && branch_valid && (branch_addr > lock_byte_addr)) begin
      ferr_src = 1'b1;
    end
    if (!is_locked(exec_addr, lock_byte_addr, lock_byte)) begin
      if (fl_attempt && is_locked(xwr_addr, lock_byte_addr, lock_byte)) begin
        ferr_src = 1'b1;
      end
      if (live && code_rd_valid &&
          is_locked(code_rd_addr, lock_byte_addr, lock_byte)) begin
        ferr_src = 1'b1;
      end
    end
    if (fl_attempt && !(supply_monitor_enable && supply_monitor_level)) begin
      ferr_src = 1'b1;
    end
  end

  // Collect every reset source of this cycle
  always_comb begin
    src = '0;
    src.pin = !sync2[0];
    src.por = vdd_src_en && sync2[3];
    src.mcd = mcd_en && sync2[1];
    src.wdog = wd_expire;
    src.ferr = ferr_src;
    src.cmp = cmp_en && sync2[2];
    src.sw = rst_wr && sfr_req.wdata[BIT_SW];
  end
  assign event_any = |src;
  // One cause recorded; pin wins, then monitor, clock, watchdog, flash
  always_comb begin
    next_flags = '0;
    if (src.pin) begin
      next_flags.pin = 1'b1;
    end else if (src.por) begin
      next_flags.por = 1'b1;
    end else if (src.mcd) begin
      next_flags.mcd = 1'b1;
    end else if (src.wdog) begin
      next_flags.wdog = 1'b1;
    end else if (src.ferr) begin
      next_flags.ferr = 1'b1;
    end else if (src.cmp) begin
      next_flags.cmp = 1'b1;
    end else begin
      next_flags.sw = src.sw;
    end
  end

  // Cause flags; power-on sets bit 1, software writes change them only by forcing a bit 4 reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_flags <= CAUSE_POR;
    end else if (event_any) begin
      reset_flags <= next_flags;
    end
  end

  // System reset output, held for a fixed time after the last source
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_reset <= 1'b1;
      hold_cnt <= RST_HOLD;
    end else if (event_any) begin
      sys_reset <= 1'b1;
      hold_cnt <= RST_HOLD;
    end else if (hold_cnt != 5'h00) begin
      hold_cnt <= hold_cnt - 5'h01;
      sys_reset <= (hold_cnt != 5'h01);
    end
  end

  // Reset source enables; monitor selection survives system resets
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
      vdd_src_en <= 1'b1;
    end else if (event_any) begin
      cmp_en <= 1'b0;
      mcd_en <= 1'b0;
    end else if (rst_wr) begin
      cmp_en <= sfr_req.wdata[BIT_CMP];
      mcd_en <= sfr_req.wdata[BIT_MCD];
      vdd_src_en <= sfr_req.wdata[BIT_POR];
    end
  end

  // Program store enables, held until software or a reset clears them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_wr_en <= 1'b0;
      ps_erase_en <= 1'b0;
    end else if (event_any) begin
      ps_wr_en <= 1'b0;
      ps_erase_en <= 1'b0;
    end else if (ps_wr) begin
      ps_wr_en <= sfr_req.wdata[BIT_WR_EN];
      ps_erase_en <= sfr_req.wdata[BIT_ERASE_EN];
    end
  end

  // An operation is started only with the keys open and no error
  assign op_go = fl_attempt && (key_state == KEY_OPEN) && !event_any;
  // Key sequence: first, second, one operation, then relock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_state <= KEY_IDLE;
    end else if (event_any) begin
      key_state <= KEY_IDLE;
    end else begin
      unique case (key_state)
        KEY_IDLE: begin
          if (key_wr) begin
            key_state <= (sfr_req.wdata == KEY_FIRST) ? KEY_ONE
                                                      : KEY_DEAD;
          end else if (fl_attempt) begin
            key_state <= KEY_DEAD;
          end
        end
        KEY_ONE: begin
          if (key_wr) begin
            key_state <= (sfr_req.wdata == KEY_SECOND) ? KEY_OPEN
                                                       : KEY_DEAD;
          end else if (fl_attempt) begin
            key_state <= KEY_DEAD;
          end
        end
        KEY_OPEN: begin
          if (op_go) begin
            key_state <= KEY_IDLE;
          end else if (key_wr) begin
            key_state <= KEY_DEAD;
          end
        end
        KEY_DEAD: begin
          key_state <= KEY_DEAD;
        end
      endcase
    end
  end

  // Flash operation sequencer and array command
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_state <= OP_IDLE;
      fl_cmd <= '0;
      wdata_hold <= '0;
    end else begin
      unique case (op_state)
        OP_IDLE: begin
          if (op_go && ps_erase_en) begin
            op_state <= OP_ERASE;
            fl_cmd.erase <= 1'b1;
            fl_cmd.addr <= {xwr_addr[15:PAGE_BITS], {PAGE_BITS{1'b0}}};
            fl_cmd.data <= ERASED_BYTE;
          end else if (op_go) begin
            op_state <= OP_FETCH;
            fl_cmd.addr <= xwr_addr;
            wdata_hold <= xwr_data;
          end
        end
        OP_FETCH: begin
          op_state <= OP_PROG;
          fl_cmd.write <= 1'b1;
          fl_cmd.data <= fl_rdata & wdata_hold;
        end
        OP_PROG, OP_ERASE: begin
          if (tmr_done) begin
            op_state <= OP_IDLE;
            fl_cmd <= '0;
          end
        end
      endcase
    end
  end

  // Stall the core for the whole operation
  assign cpu_stall = (op_state != OP_IDLE);
  assign tmr_start = (op_state == OP_FETCH) || (op_go && ps_erase_en);
  assign tmr_load = (op_state == OP_FETCH) ? TMR_W'(WRITE_CNT)
                                           : TMR_W'(ERASE_CNT);
  rsfg_op_timer #(
    .W(TMR_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );
  rsfg_watchdog #(
    .LIMIT(WD_TICKS)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clear(event_any),
    .kick(wd_kick),
    .disable_wd(wd_disable),
    .expire(wd_expire)
  );

  // Register read port, one cycle latency, unmapped reads give zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= '0;
    end else if (sfr_req.rd) begin
      if (sfr_req.addr == RST_CAUSE_ADDR) begin
        sfr_rdata <= {1'b1, reset_flags};
      end else if (sfr_req.addr == PS_CTRL_ADDR) begin
        sfr_rdata <= {6'h00, ps_erase_en, ps_wr_en};
      end else if (sfr_req.addr == FL_KEY_ADDR) begin
        sfr_rdata <= {6'h00, key_state};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_wdog_flag: assert property (
    (src == 7'h08) |=> (sys_reset && reset_flags == 7'h08))
    else $error("watchdog expiry not recorded");
  a_xwr_range: assert property (
    (fl_attempt && xwr_addr > lock_byte_addr && !src.pin && !src.por &&
     !src.mcd && !src.wdog) |=> (reset_flags.ferr && sys_reset))
    else $error("write above lock address not trapped");
  a_code_rd_range: assert property (
    (live && code_rd_valid && code_rd_addr > lock_byte_addr &&
     !src.pin && !src.por && !src.mcd && !src.wdog) |=> reset_flags.ferr)
    else $error("code read above lock address not trapped");
  a_branch_range: assert property (
    (live && branch_valid && branch_addr > lock_byte_addr && !src.pin &&
     !src.por && !src.mcd && !src.wdog) |=> reset_flags == 7'h40)
    else $error("branch above lock address not trapped");
  a_vdd_guard: assert property (
    (fl_attempt && !supply_monitor_level) |=> op_state == OP_IDLE)
    else $error("flash operation without high monitor");
  a_sw_force: assert property (
    (src == 7'h10) |=> (sys_reset && reset_flags.sw) [*2])
    else $error("software reset not forced");
  a_ro_bit7: assert property (
    (sfr_req.rd && sfr_req.addr == RST_CAUSE_ADDR) |=> sfr_rdata[7])
    else $error("bit 7 of reset source not one");
  a_stall_op: assert property (
    (fl_cmd.write || fl_cmd.erase) |-> cpu_stall)
    else $error("core not stalled during operation");
  a_write_clear: assert property (
    (op_state == OP_FETCH) |=> ((fl_cmd.data | $past(fl_rdata)) ==
                                $past(fl_rdata)))
    else $error("flash write sets a bit");
  a_erase_page: assert property (
    fl_cmd.erase |-> (fl_cmd.addr[PAGE_BITS-1:0] == '0))
    else $error("erase address not page aligned");
  a_key_dead: assert property (
    (key_state == KEY_IDLE && key_wr && sfr_req.wdata != KEY_FIRST &&
     !event_any) |=> key_state == KEY_DEAD ##1 key_state == KEY_DEAD)
    else $error("wrong key did not lock flash");
  a_relock: assert property (
    $fell(cpu_stall) |-> key_state != KEY_OPEN)
    else $error("flash not relocked after operation");
  a_short_addr: assert property (
    (live && xwr_valid && xwr_short && xwr_addr[15:8] != 8'h00) |=> !cpu_stall)
    else $error("short write reached high flash");

  c_erase: cover property (op_state == OP_IDLE ##1 op_state == OP_ERASE);
  c_write: cover property (op_state == OP_FETCH ##1 op_state == OP_PROG);
  c_ferr: cover property (src == 7'h40);
  c_swrst: cover property (src.sw ##1 sys_reset);
endmodule : rsfg_guard

//--- rsfg_guard_tb.sv
/*
  Self-checking testbench for rsfg_guard: drives register accesses, data
  writes, code reads, branches and reset sources at the falling edge.
  Assumes shortened timing parameters and a kick stream for the watchdog.
*/
`timescale 1ns/1ps
module rsfg_guard_tb import rsfg_pkg::*;;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  rsfg_sfr_s sfr_req = '0;
  logic [7:0] sfr_rdata, xwr_data = 8'h00, lock_byte = 8'hFF;
  logic [7:0] fl_rdata = 8'hF0;
  logic xwr_valid = 1'h0, xwr_short = 1'h0, code_rd_valid = 1'h0;
  logic branch_valid = 1'h0, wd_kick = 1'h0, wd_disable = 1'h0;
  logic [15:0] xwr_addr = '0, code_rd_addr = '0, branch_addr = '0;
  logic [15:0] exec_addr = 16'h0400, lock_byte_addr = 16'h1DFF;
  logic supply_monitor_enable = 1'h1, supply_monitor_level = 1'h1;
  logic supply_trip = 1'h0, rst_pin_n = 1'h1, mcd_timeout = 1'h0;
  logic comparator_low = 1'h0, kick_on = 1'h1, cpu_stall, sys_reset;
  logic [2:0] kc = 3'h0;
  rsfg_fl_cmd_s fl_cmd;
  int fail_count = 0;
  int n_tests = 0;

  rsfg_guard #(.WRITE_CNT(8), .ERASE_CNT(20), .WD_TICKS(4)) u_rsfg_guard (
    .ref_clk, .reset_n, .sfr_req, .sfr_rdata, .xwr_valid, .xwr_addr,
    .xwr_data, .xwr_short, .code_rd_valid, .code_rd_addr, .branch_valid,
    .branch_addr, .exec_addr, .lock_byte_addr, .lock_byte, .wd_kick,
    .wd_disable, .supply_monitor_enable, .supply_monitor_level,
    .supply_trip, .rst_pin_n, .mcd_timeout, .comparator_low, .fl_rdata,
    .fl_cmd, .cpu_stall, .sys_reset);

  // Clock source, 8 ns period
  initial forever #4 ref_clk = ~ref_clk;

  // Kick every 8 cycles, well inside the 48-cycle expiry
  always @(negedge ref_clk) begin
    kc <= kc + 3'h1;
    wd_kick <= kick_on && kc == 3'h0;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk1

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  function automatic logic sig(input int s);
    case (s)
      0: return sys_reset;
      1: return cpu_stall;
      2: return fl_cmd.write;
      default: return fl_cmd.erase;
    endcase
  endfunction : sig

  // Bounded wait on one status output; running out ends the run
  task automatic waitv(input int s, input logic v, input int n,
                       input string m);
    for (int i = 0; i < n && sig(s) !== v; i++) @(negedge ref_clk);
    chk1(sig(s), v, m);
    if (sig(s) !== v) conclude;
  endtask : waitv

  task automatic sfr(input bit wr, input logic [7:0] a, d);
    @(negedge ref_clk);
    sfr_req = {wr, !wr, a, d};
    @(negedge ref_clk);
    sfr_req = '0;
  endtask : sfr

  task automatic rd(input logic [7:0] a, exp, input string m);
    sfr(1'b0, a, 8'h00);
    @(negedge ref_clk);
    chk({8'h00, sfr_rdata}, {8'h00, exp}, m);
  endtask : rd

  task automatic xwr(input logic [15:0] a, input logic [7:0] d,
                     input logic s);
    @(negedge ref_clk);
    xwr_valid = 1'h1;
    xwr_addr = a;
    xwr_data = d;
    xwr_short = s;
    @(negedge ref_clk);
    xwr_valid = 1'h0;
  endtask : xwr

  task automatic strobe(input bit br, input logic [15:0] a);
    @(negedge ref_clk);
    code_rd_valid = !br;
    branch_valid = br;
    code_rd_addr = a;
    branch_addr = a;
    @(negedge ref_clk);
    code_rd_valid = 1'h0;
    branch_valid = 1'h0;
  endtask : strobe

  task automatic unlock;
    sfr(1'b1, FL_KEY_ADDR, KEY_FIRST);
    sfr(1'b1, FL_KEY_ADDR, KEY_SECOND);
  endtask : unlock

  task automatic expect_rst(input logic [7:0] exp, input int n,
                            input string m);
    waitv(0, 1'h1, n, m);
    waitv(0, 1'h0, 60, m);
    rd(RST_CAUSE_ADDR, exp, m);
  endtask : expect_rst

  task automatic t_por;
    waitv(0, 1'h0, 60, "power-on release");
    rd(RST_CAUSE_ADDR, 8'h82, "power-on flags");
    $display("power-on test done");
  endtask : t_por

  task automatic t_swrst;
    sfr(1'b1, RST_CAUSE_ADDR, 8'hCB);
    repeat (3) @(negedge ref_clk);
    chk1(sys_reset, 1'h0, "flag write reset");
    rd(RST_CAUSE_ADDR, 8'h82, "flags after ro write");
    sfr(1'b1, RST_CAUSE_ADDR, 8'h12);
    expect_rst(8'h90, 20, "sw reset");
    $display("software reset test done");
  endtask : t_swrst

  task automatic t_write;
    unlock();
    sfr(1'b1, PS_CTRL_ADDR, 8'h01);
    xwr(16'h0180, 8'h3C, 1'h1);
    repeat (3) @(negedge ref_clk);
    chk1(cpu_stall, 1'h0, "short write above 0xFF");
    xwr(16'h0100, 8'h3C, 1'h0);
    waitv(1, 1'h1, 4, "write stall");
    waitv(2, 1'h1, 4, "write strobe");
    chk(fl_cmd.addr, 16'h0100, "write addr");
    chk({8'h00, fl_cmd.data}, 16'h0030, "write data");
    waitv(1, 1'h0, 20, "write end");
    chk1(fl_cmd.write, 1'h0, "write released");
    rd(FL_KEY_ADDR, 8'h00, "relocked");
    rd(PS_CTRL_ADDR, 8'h01, "enable held");
    xwr(16'h0101, 8'h00, 1'h0);
    repeat (3) @(negedge ref_clk);
    chk1(cpu_stall, 1'h0, "write without keys");
    rd(FL_KEY_ADDR, 8'h03, "early write kills key");
    sfr(1'b1, RST_CAUSE_ADDR, 8'h12);
    expect_rst(8'h90, 20, "sw reset");
    $display("flash write test done");
  endtask : t_write

  task automatic t_erase;
    unlock();
    sfr(1'b1, PS_CTRL_ADDR, 8'h03);
    xwr(16'h0345, 8'h00, 1'h0);
    waitv(3, 1'h1, 4, "erase strobe");
    chk(fl_cmd.addr, 16'h0200, "erase page");
    chk({8'h00, fl_cmd.data}, 16'h00FF, "erase fill");
    waitv(1, 1'h0, 40, "erase end");
    sfr(1'b1, PS_CTRL_ADDR, 8'h00);
    sfr(1'b1, FL_KEY_ADDR, 8'h5A);
    rd(FL_KEY_ADDR, 8'h03, "wrong key");
    unlock();
    sfr(1'b1, PS_CTRL_ADDR, 8'h01);
    xwr(16'h0100, 8'h00, 1'h0);
    repeat (3) @(negedge ref_clk);
    chk1(cpu_stall, 1'h0, "locked until reset");
    sfr(1'b1, RST_CAUSE_ADDR, 8'h12);
    expect_rst(8'h90, 20, "sw reset");
    $display("erase and key test done");
  endtask : t_erase

  task automatic t_ferr;
    for (int k = 0; k < 6; k++) begin
      lock_byte = (k == 3) ? 8'hFE : 8'hFF;
      supply_monitor_enable = k != 4;
      supply_monitor_level = k != 5;
      if (k == 0 || k > 3) begin
        unlock();
        sfr(1'b1, PS_CTRL_ADDR, 8'h01);
      end
      case (k)
        0: xwr(16'h1E00, 8'h00, 1'h0);
        1: strobe(1'b0, 16'h1E00);
        2: strobe(1'b1, 16'h1E00);
        3: strobe(1'b0, 16'h0010);
        default: xwr(16'h0300, 8'h00, 1'h0);
      endcase
      expect_rst(8'hC0, 20, "flash error reset");
    end
    lock_byte = 8'hFF;
    supply_monitor_enable = 1'h1;
    supply_monitor_level = 1'h1;
    $display("flash error test done");
  endtask : t_ferr

  task automatic t_sources;
    logic [7:0] exp [4] = '{8'h81, 8'h84, 8'hA0, 8'h82};
    kick_on = 1'h0;
    wd_disable = 1'h1;
    repeat (70) @(negedge ref_clk);
    chk1(sys_reset, 1'h0, "watchdog held off");
    wd_disable = 1'h0;
    expect_rst(8'h88, 90, "watchdog reset");
    kick_on = 1'h1;
    for (int k = 0; k < 4; k++) begin
      if (k == 1) sfr(1'b1, RST_CAUSE_ADDR, 8'h06);
      if (k == 2) sfr(1'b1, RST_CAUSE_ADDR, 8'h22);
      rst_pin_n = k != 0;
      mcd_timeout = k == 1;
      comparator_low = k == 2;
      supply_trip = k == 3;
      repeat (4) @(negedge ref_clk);
      {mcd_timeout, comparator_low, supply_trip} = 3'h0;
      rst_pin_n = 1'h1;
      expect_rst(exp[k], 20, "source reset");
    end
    $display("reset source test done");
  endtask : t_sources

  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    reset_n = 1'h1;
    t_por();
    t_swrst();
    t_write();
    t_erase();
    t_ferr();
    t_sources();
    conclude();
  end
endmodule : rsfg_guard_tb
